// File: rtl/nli_pkg.sv
// nli_pkg: shared constants and types for the network indicator block.
// assumes one 10 MHz core clock and synchronous active-high reset.
package nli_pkg;

    // ------------------------------------------------------------
    // clock and blink timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;  // core clock rate
    localparam int BLINK_ON_MS     = 40;          // visible low time per event
    localparam int BLINK_OFF_MS    = 40;          // forced high gap after it
    localparam int BLINK_ON_CYC    = (CLK_HZ / 1000) * BLINK_ON_MS;
    localparam int BLINK_OFF_CYC   = (CLK_HZ / 1000) * BLINK_OFF_MS;
    localparam int BLINK_CNT_W     = 22;          // wide enough for both counts

    // ------------------------------------------------------------
    // mode select encodings and reset default
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SPEED_SPLIT = 2'h0;  // 00
    localparam logic [1:0] MODE_SPEED_GROUP = 2'h1;  // 01
    localparam logic [1:0] MODE_TX_RX_DUPLX = 2'h2;  // 10
    localparam logic [1:0] MODE_LINK_ACT    = 2'h3;  // 11
    localparam logic [1:0] MODE_DEFAULT     = 2'h3;  // used with no config memory

    // ------------------------------------------------------------
    // blink stretcher phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NLI_BLINK_IDLE = 2'b00,
        NLI_BLINK_ON   = 2'b01,
        NLI_BLINK_OFF  = 2'b10
    } nli_blink_phase_t;

    // link and activity status from the core
    typedef struct packed {
        logic link_up;
        logic speed_10m;
        logic speed_100m;
        logic speed_1000m;
        logic full_duplex;
        logic tx_activity;
        logic rx_activity;
    } nli_status_t;

    // mode loader state
    typedef struct packed {
        logic       loaded;
        logic [1:0] mode;
    } nli_mode_state_t;

endpackage : nli_pkg

// File: rtl/nli_blink.sv
// nli_blink: stretches activity events into a high lit_out pulse plus a low gap.
// assumes the event input is synchronous to clk_in.
`timescale 1ns/1ps

module nli_blink (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // event in, lamp-on request out (active high)
    input  wire logic event_in,
    output logic      lit_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        nli_pkg::nli_blink_phase_t        phase;  // current phase
        logic [nli_pkg::BLINK_CNT_W-1:0]  count;  // cycles left in phase
    } nli_blink_state_t;

    nli_blink_state_t cur;       // registered state
    nli_blink_state_t next_cur;  // next value

    localparam logic [nli_pkg::BLINK_CNT_W-1:0] ON_LOAD  =
        nli_pkg::BLINK_CNT_W'(nli_pkg::BLINK_ON_CYC - 1);
    localparam logic [nli_pkg::BLINK_CNT_W-1:0] OFF_LOAD =
        nli_pkg::BLINK_CNT_W'(nli_pkg::BLINK_OFF_CYC - 1);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // events during a pulse or gap are absorbed; a busy stream blinks
    // at a steady period instead of holding the lamp solid on.
    always_comb begin
        next_cur = cur;
        case (cur.phase)
            nli_pkg::NLI_BLINK_IDLE: begin
                if (event_in) begin
                    next_cur.phase = nli_pkg::NLI_BLINK_ON;
                    next_cur.count = ON_LOAD;
                end
            end
            nli_pkg::NLI_BLINK_ON: begin
                if (cur.count == '0) begin
                    next_cur.phase = nli_pkg::NLI_BLINK_OFF;
                    next_cur.count = OFF_LOAD;
                end else begin
                    next_cur.count = cur.count - 1'b1;
                end
            end
            nli_pkg::NLI_BLINK_OFF: begin
                if (cur.count == '0) begin
                    next_cur.phase = nli_pkg::NLI_BLINK_IDLE;
                end else begin
                    next_cur.count = cur.count - 1'b1;
                end
            end
            default: begin
                next_cur.phase = nli_pkg::NLI_BLINK_IDLE;
                next_cur.count = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur.phase <= nli_pkg::NLI_BLINK_IDLE;
            cur.count <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // lamp lit only during the on phase
    assign lit_out = (cur.phase == nli_pkg::NLI_BLINK_ON);

endmodule // nli_blink

// File: rtl/nli_top.sv
// nli_top: maps link, speed, duplex and activity onto four indicator
// outputs and a link-state output.
// assumes status inputs synchronous to clk_in; the config loader pulses
// cfg_done_in once after reset, with cfg_valid_in high when a config memory answered.
`timescale 1ns/1ps

module nli_top (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // status from the mac and phy
    input  wire nli_pkg::nli_status_t status_in,
    input  wire logic                power_down_in,
    // mode select load from config memory
    input  wire logic                cfg_done_in,
    input  wire logic                cfg_valid_in,
    input  wire logic [1:0]          cfg_mode_in,
    // indicators, active low
    output logic                     indicator_out_0,
    output logic                     indicator_out_1,
    output logic                     indicator_out_2,
    output logic                     indicator_out_3,
    // link-state output, high when up
    output logic                     link_state_out,
    // current mode, for observation
    output logic [1:0]               indicator_mode_select_out
);

    // ------------------------------------------------------------
    // helper: a link lamp for a given speed
    // ------------------------------------------------------------
    function automatic logic link_at(input logic up, input logic speed);
        link_at = up & speed;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        nli_pkg::nli_mode_state_t mode_st;  // mode and load flag
        logic [3:0]               lamp_n;   // registered indicators
        logic                     link;     // registered link state
    } nli_top_state_t;

    nli_top_state_t cur;       // registered state
    nli_top_state_t next_cur;  // next value

    logic tx_lit;     // stretched transmit activity
    logic rx_lit;     // stretched receive activity
    logic any_lit;    // stretched combined activity
    logic tx_evt;     // transmit event while linked
    logic rx_evt;     // receive event while linked
    logic any_evt;    // either event
    logic [3:0] lit;  // active-high lamp requests

    // activity counts only with a link; a link-less stream is noise
    assign tx_evt  = status_in.tx_activity & status_in.link_up;
    assign rx_evt  = status_in.rx_activity & status_in.link_up;
    assign any_evt = tx_evt | rx_evt;

    // ------------------------------------------------------------
    // pulse stretchers
    // ------------------------------------------------------------
    // three separate stretchers so combined and split lamps stay in
    // their own rhythm; costs a little area over sharing one.
    nli_blink u_tx_blink (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .event_in (tx_evt),
        .lit_out  (tx_lit)
    );

    nli_blink u_rx_blink (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .event_in (rx_evt),
        .lit_out  (rx_lit)
    );

    nli_blink u_any_blink (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .event_in (any_evt),
        .lit_out  (any_lit)
    );

    // ------------------------------------------------------------
    // lamp mapping per mode
    // ------------------------------------------------------------
    // link/activity lamps sit lit while up and dark on each blink pulse,
    // so a busy link flickers and a dead link stays dark (high).
    always_comb begin
        lit = 4'h0;
        case (cur.mode_st.mode)
            nli_pkg::MODE_SPEED_SPLIT: begin
                lit[0] = any_lit;
                lit[1] = link_at(status_in.link_up, status_in.speed_100m);
                lit[2] = link_at(status_in.link_up, status_in.speed_10m);
                lit[3] = link_at(status_in.link_up, status_in.speed_1000m);
            end
            nli_pkg::MODE_SPEED_GROUP: begin
                lit[0] = any_lit;
                lit[1] = status_in.link_up;
                lit[2] = link_at(status_in.link_up,
                                 status_in.speed_10m | status_in.speed_100m);
                lit[3] = link_at(status_in.link_up, status_in.speed_1000m);
            end
            nli_pkg::MODE_TX_RX_DUPLX: begin
                lit[0] = tx_lit;
                lit[1] = status_in.link_up;
                lit[2] = rx_lit;
                lit[3] = status_in.link_up & status_in.full_duplex;
            end
            nli_pkg::MODE_LINK_ACT: begin
                lit[0] = link_at(status_in.link_up, status_in.speed_10m) & ~any_lit;
                lit[1] = link_at(status_in.link_up, status_in.speed_100m) & ~any_lit;
                lit[2] = status_in.link_up & status_in.full_duplex;
                lit[3] = link_at(status_in.link_up, status_in.speed_1000m) & ~any_lit;
            end
            default: begin
                lit = 4'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        // mode loads once; without a config memory the default stays
        if (!cur.mode_st.loaded && cfg_done_in) begin
            next_cur.mode_st.loaded = 1'b1;
            if (cfg_valid_in) begin
                next_cur.mode_st.mode = cfg_mode_in;
            end
        end
        // outputs active low; power-down darkens every lamp
        if (power_down_in) begin
            next_cur.lamp_n = 4'hF;
        end else begin
            next_cur.lamp_n = ~lit;
        end
        next_cur.link = status_in.link_up;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur.mode_st.loaded <= 1'b0;
            cur.mode_st.mode   <= nli_pkg::MODE_DEFAULT;
            cur.lamp_n         <= 4'hF;
            cur.link           <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign indicator_out_0           = cur.lamp_n[0];
    assign indicator_out_1           = cur.lamp_n[1];
    assign indicator_out_2           = cur.lamp_n[2];
    assign indicator_out_3           = cur.lamp_n[3];
    assign link_state_out            = cur.link;
    assign indicator_mode_select_out = cur.mode_st.mode;

endmodule // nli_top

// File: sim/nli_led_board.sv
// nli_led_board: board lamps hung on the four indicator pins
// assumes each pin sinks its lamp current, so a low pin means lit
`timescale 1ns/1ps

module nli_led_board (
    // pins from the device, active low
    input  wire logic [3:0] ind_n_in,
    // lamp states seen by the bench
    output logic      [3:0] lit_out
);
    // a lamp glows only while its pin pulls low; pull-ups keep it dark
    assign lit_out = ~ind_n_in;
endmodule // nli_led_board

// File: sim/nli_props.sv
// nli_props: port checks for the indicator block
// assumes it is bound onto nli_top and sees its ports only
`timescale 1ns/1ps

module nli_props (
    // clock and reset
    input wire logic                 clk_in,
    input wire logic                 rst_in,
    // inputs of the block
    input wire nli_pkg::nli_status_t status_in,
    input wire logic                 power_down_in,
    input wire logic                 cfg_done_in,
    input wire logic                 cfg_valid_in,
    input wire logic [1:0]           cfg_mode_in,
    // outputs of the block
    input wire logic                 indicator_out_0,
    input wire logic                 indicator_out_1,
    input wire logic                 indicator_out_2,
    input wire logic                 indicator_out_3,
    input wire logic                 link_state_out,
    input wire logic [1:0]           indicator_mode_select_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic       cfg_seen; // first load taken
    logic       act_seen; // stretcher may be busy, lamp state unknown
    logic [1:0] m;        // mode shown by the block
    logic       up;       // link status in
    logic       on;       // not in power-down
    logic       act;      // either activity in
    logic       l10;      // linked at 10M
    logic       l100;     // linked at 100M
    logic       l1g;      // linked at 1000M
    logic       fdx;      // linked at full duplex
    logic [3:0] ind;      // the four lamp pins
    assign m    = indicator_mode_select_out;
    assign up   = status_in.link_up;
    assign on   = !power_down_in;
    assign act  = status_in.tx_activity || status_in.rx_activity;
    assign l10  = up && status_in.speed_10m;
    assign l100 = up && status_in.speed_100m;
    assign l1g  = up && status_in.speed_1000m;
    assign fdx  = up && status_in.full_duplex;
    assign ind  = {indicator_out_3, indicator_out_2, indicator_out_1, indicator_out_0};
    // history flags, cleared by reset like the block itself
    always_ff @(posedge clk_in) begin
        cfg_seen <= !rst_in && (cfg_seen || cfg_done_in);
        act_seen <= !rst_in && (act_seen || (up && act));
    end
    // first activity event with the mode held for the next edge
    sequence s_first(logic a, logic [1:0] md);
        on && m == md && !act_seen && up && a ##1 on && m == md;
    endsequence
    chk_pd_dark: assert property (!on |=> ind == 4'hF)
        else $error("lamp lit in power-down");
    chk_link_state: assert property (1'b1 |=> link_state_out == $past(up))
        else $error("link out");
    chk_mode_default: assert property (!cfg_seen && !(cfg_done_in && cfg_valid_in)
        |=> m == 2'h3) else $error("mode not default");
    chk_mode_load: assert property (!cfg_seen && cfg_done_in && cfg_valid_in
        |=> m == $past(cfg_mode_in)) else $error("mode not loaded");
    chk_mode_hold: assert property (cfg_seen |=> $stable(m))
        else $error("mode moved");
    chk_map_split: assert property (on && m == 2'h0
        |=> ind[3:1] == ~$past({l1g, l10, l100})) else $error("mode 0 map");
    chk_map_group: assert property (on && m == 2'h1
        |=> ind[3:1] == ~$past({l1g, l10 || l100, up})) else $error("mode 1 map");
    chk_map_duplex: assert property (on && m == 2'h2
        |=> {ind[3], ind[1]} == ~$past({fdx, up})) else $error("mode 2 map");
    chk_map_full: assert property (on && m == 2'h3
        |=> ind[2] == !$past(fdx)) else $error("mode 3 map");
    chk_steady_link: assert property (on && m == 2'h3 && !act_seen
        |=> {ind[3], ind[1], ind[0]} == ~$past({l1g, l100, l10}))
        else $error("link lamp not steady");
    chk_tx_blink: assert property (s_first(status_in.tx_activity, 2'h2)
        |=> !indicator_out_0 [*8]) else $error("tx lamp");
    chk_rx_blink: assert property (s_first(status_in.rx_activity, 2'h2)
        |=> !indicator_out_2 [*8]) else $error("rx lamp");
    chk_both_blink: assert property (s_first(act, 2'h0)
        |=> !indicator_out_0 [*8]) else $error("tx/rx lamp");
    chk_act_dark: assert property (s_first(act, 2'h3)
        |=> (ind[3] && ind[1] && ind[0]) [*8]) else $error("link/act lamp");
endmodule // nli_props

bind nli_top nli_props i_nli_props (.clk_in(clk_in), .rst_in(rst_in), .status_in(status_in),
    .power_down_in(power_down_in), .cfg_done_in(cfg_done_in), .cfg_valid_in(cfg_valid_in),
    .cfg_mode_in(cfg_mode_in), .indicator_out_0(indicator_out_0),
    .indicator_out_1(indicator_out_1), .indicator_out_2(indicator_out_2),
    .indicator_out_3(indicator_out_3), .link_state_out(link_state_out),
    .indicator_mode_select_out(indicator_mode_select_out));

// File: sim/nli_top_tb.sv
// nli_top_tb: runs cycling mode and power-down over random status, with queued expectations
// assumes nli_top, the lamp board model and the bound checker
`timescale 1ns/1ps

module nli_top_tb;
    logic                 clk_in     = 1'b0;
    logic                 rst_in     = 1'b1;
    nli_pkg::nli_status_t st         = '0;
    logic                 pd         = 1'b0;
    logic                 done       = 1'b0;
    logic                 valid      = 1'b0;
    logic [1:0]           cmode      = 2'h0;
    logic [3:0]           ind;
    logic [3:0]           lit;
    logic                 lnk;
    logic [1:0]           msel;
    logic [6:0]           exp_q[$];
    int                   num_errors = 0;
    int                   cmp_count  = 0;
    event                 look;

    always #50 clk_in = ~clk_in;
    nli_top i_nli_top (.clk_in(clk_in), .rst_in(rst_in), .status_in(st), .power_down_in(pd),
        .cfg_done_in(done), .cfg_valid_in(valid), .cfg_mode_in(cmode),
        .indicator_out_0(ind[0]), .indicator_out_1(ind[1]), .indicator_out_2(ind[2]),
        .indicator_out_3(ind[3]), .link_state_out(lnk), .indicator_mode_select_out(msel));
    nli_led_board i_nli_led_board (.ind_n_in(ind), .lit_out(lit));

    // inputs move a fixed 2 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic check(input logic [6:0] seen, input logic [6:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // expected {mode, link, lamps lit}; a stretched blink is still lit when looked at
    function automatic logic [6:0] model(input logic [1:0] md, input nli_pkg::nli_status_t s,
                                         input logic dn);
        logic       u;
        logic       t;
        logic       r;
        logic       b;
        logic [3:0] on;
        u = s.link_up;
        t = u && s.tx_activity;
        r = u && s.rx_activity;
        b = t || r;
        case (md)
            2'h0: on = {u && s.speed_1000m, u && s.speed_10m, u && s.speed_100m, b};
            2'h1: on = {u && s.speed_1000m, u && (s.speed_10m || s.speed_100m), u, b};
            2'h2: on = {u && s.full_duplex, r, u, t};
            default: on = {u && s.speed_1000m && !b, u && s.full_duplex,
                           u && s.speed_100m && !b, u && s.speed_10m && !b};
        endcase
        return {md, u, dn ? 4'h0 : on};
    endfunction
    // watcher: oldest note against the mode, link state and lamps shown
    always @(look) begin
        logic [6:0] want;
        want = exp_q.pop_front();
        check({5'h0, msel}, {5'h0, want[6:5]});
        check({6'h0, lnk}, {6'h0, want[4]});
        check({3'h0, lit}, {3'h0, want[3:0]});
    end

    initial begin
        logic [1:0] m;
        int         sp;
        void'($urandom(51470));
        for (int i = 0; i < 40; i++) begin
            rst_in = 1'b1;
            pd = 1'b0;
            st = '0;
            step(16);
            rst_in = 1'b0;
            step(1);
            m = 2'(i);
            valid = (i % 5 != 4);
            cmode = m;
            done = 1'b1;
            step(1);
            done = 1'b0;
            sp = $urandom_range(2, 0);
            st.link_up = (i % 3 != 2);
            st.speed_10m = (sp == 0);
            st.speed_100m = (sp == 1);
            st.speed_1000m = (sp == 2);
            st.full_duplex = 1'($urandom);
            st.tx_activity = 1'($urandom);
            st.rx_activity = 1'($urandom);
            pd = (i % 7 == 6);
            if (!valid)
                m = 2'h3;
            exp_q.push_back(model(m, st, pd));
            step(1);
            st.tx_activity = 1'b0;
            st.rx_activity = 1'b0;
            valid = 1'b1;
            cmode = ~m;
            done = 1'b1;
            step(1);
            done = 1'b0;
            // long enough for the checker's eight-cycle blink windows to close
            step(10);
            -> look;
            $display("test %0d done", i);
        end
        tally_and_finish;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        tally_and_finish;
    end
endmodule // nli_top_tb
